// ==== tb/tb.sv ====
// self-checking bench for the key-serviced watchdog
`timescale 1ns/1ps
`include "wdt_defines.svh"
module tb;
    logic       clk_in        = 1'b0;
    logic       srst_in       = 1'b1;
    logic       osc_tick_in   = 1'b0;
    logic       osc_run_in    = 1'b1;
    logic       count_hold_in = 1'b0;
    logic       key_wr_in     = 1'b0;
    logic       key_bit_op_in = 1'b0;
    logic [7:0] key_wdata_in  = 8'h00;
    logic       key_rd_in     = 1'b0;
    logic [7:0] key_rdata_out;
    logic       cnt_clear_out;
    logic       internal_rst_out;
    int         fails         = 0;
    int         check_count   = 0;
    logic [7:0] v;
    // 250 MHz clock
    always #2 clk_in = ~clk_in;
    watchdog_key_reset_unit dut_u (.clk_in(clk_in), .srst_in(srst_in), .osc_tick_in(osc_tick_in),
        .osc_run_in(osc_run_in), .count_hold_in(count_hold_in), .key_wr_in(key_wr_in),
        .key_bit_op_in(key_bit_op_in), .key_wdata_in(key_wdata_in), .key_rd_in(key_rd_in),
        .key_rdata_out(key_rdata_out), .cnt_clear_out(cnt_clear_out),
        .internal_rst_out(internal_rst_out));
    // inputs move 1 ns after the edge so the design never races the bench
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_in);
            #1;
        end
    endtask
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    function automatic logic [7:0] exp_read(input logic ticked);
        return ticked ? `WDT_READ_RUN : `WDT_READ_IDLE;
    endfunction
    // a bit access is illegal whatever data rides along
    function automatic logic exp_rst(input logic [7:0] d, input logic bit_op);
        return bit_op || (d !== `WDT_KEY);
    endfunction
    task automatic do_reset;
        srst_in = 1'b1;
        step(2);
        srst_in = 1'b0;
    endtask
    task automatic access(input logic wr, input logic bo, input logic [7:0] d);
        key_wr_in = wr;
        key_bit_op_in = bo;
        key_wdata_in = d;
        step(1);
        key_wr_in = 1'b0;
        key_bit_op_in = 1'b0;
    endtask
    task automatic read_chk(input logic ticked);
        key_rd_in = 1'b1;
        step(1);
        key_rd_in = 1'b0;
        check(key_rdata_out === exp_read(ticked), "read pattern");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        v = 8'($urandom(22));
        do_reset();
        read_chk(1'b0);
        // first service lands at a random point after some ticks
        osc_tick_in = 1'b1;
        step($urandom_range(50, 1));
        osc_tick_in = 1'b0;
        read_chk(1'b1);
        access(1'b1, 1'b0, `WDT_KEY);
        check(cnt_clear_out === 1'b1 && internal_rst_out === 1'b0, "no clear");
        read_chk(1'b0);
        // random wrong keys, then bit access with the key, then bit access alone
        for (int i = 0; i < 6; i++) begin
            do_reset();
            v = 8'($urandom);
            if (i == 4) begin
                v = `WDT_KEY;
            end else if (v === `WDT_KEY) begin
                v = 8'h00;
            end
            access(i != 5, i >= 4, v);
            check(internal_rst_out === exp_rst(v, i >= 4), "reset mismatch");
        end
        // one idle edge so the strobes are not lowered and raised in one time step
        step(1);
        access(1'b1, 1'b0, `WDT_KEY);
        check(cnt_clear_out === 1'b0 && internal_rst_out === 1'b1, "not latched");
        // wrong key while the oscillator is stopped is held off
        do_reset();
        osc_run_in = 1'b0;
        access(1'b1, 1'b0, 8'h55);
        step(5);
        check(internal_rst_out === 1'b0, "reset while stopped");
        osc_run_in = 1'b1;
        for (int k = 0; k < 3 && internal_rst_out !== 1'b1; k++) step(1);
        check(internal_rst_out === 1'b1, "deferred reset missing");
        // overflow with a hold and a stop mid-way; the count must survive both
        do_reset();
        osc_tick_in = 1'b1;
        step(50 + $urandom_range(200, 0));
        // service on a tick cycle: the clear wins and the overflow time restarts from it
        access(1'b1, 1'b0, `WDT_KEY);
        check(cnt_clear_out === 1'b1 && internal_rst_out === 1'b0, "mid-count clear");
        step(30000);
        count_hold_in = 1'b1;
        step(50);
        count_hold_in = 1'b0;
        osc_run_in = 1'b0;
        step(50);
        osc_run_in = 1'b1;
        // 65534 ticks after the clear; the next tick is the overflow tick
        step(35534);
        check(internal_rst_out === 1'b0, "early overflow");
        step(1);
        check(internal_rst_out === 1'b1, "overflow missed");
        tally_and_finish();
    end
endmodule

// ==== verilog/watchdog_key_reset_unit.sv ====
// watchdog with key register service and internal reset request
//
// Overview of operation
// - any byte written to the key register other than the service key raises an internal reset.
// - a reset-causing key access while the watchdog clock is stopped waits until the clock runs.
// - a single-bit set, clear or test access to the key register raises an internal reset.
// - a key register read returns one of two fixed patterns, never the written key.
// - the first key write after reset clears and restarts the counter whenever it comes before overflow.
// - after a clear the overflow time may deviate by at most two low-speed oscillator periods.
// - a valid clear is accepted up to and on the overflow tick, the tick at which the counter would reach all ones.
// - when counting stops for low power or a stopped clock the count is kept and resumed.
`timescale 1ns/1ps
`include "wdt_defines.svh"

module watchdog_key_reset_unit (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       osc_tick_in,      // one pulse per low-speed oscillator period
    input  wire logic       osc_run_in,       // low-speed oscillator running
    input  wire logic       count_hold_in,    // low-power mode stops counting
    input  wire logic       key_wr_in,        // byte write strobe to key register
    input  wire logic       key_bit_op_in,    // single-bit manipulation strobe
    input  wire logic [7:0] key_wdata_in,
    input  wire logic       key_rd_in,
    output logic      [7:0] key_rdata_out,
    output logic            cnt_clear_out,    // pulse: counter cleared by service
    output logic            internal_rst_out  // level until srst_in
);
    wdt_pkg::wdt_state_e state;
    wdt_pkg::wdt_state_e next_state;
    logic [`WDT_CNT_W-1:0] count;
    logic [`WDT_CNT_W-1:0] next_count;
    logic                  tick_seen;
    logic                  next_tick_seen;
    logic [7:0]            next_key_rdata;
    logic                  next_cnt_clear;
    logic                  next_internal_rst;
    logic                  bad_access;
    logic                  good_access;
    logic                  overflow;
    logic [`WDT_CNT_W:0]   ticks_since_clear;  // shadow count, read by the checks only
    logic [`WDT_CNT_W:0]   next_ticks_since_clear;

    // decode key accesses; a bit op is always illegal whatever the data
    always_comb begin
        bad_access  = key_bit_op_in ||
                      (key_wr_in && key_wdata_in != `WDT_KEY);
        good_access = key_wr_in && !key_bit_op_in && key_wdata_in == `WDT_KEY;
        overflow    = osc_tick_in && osc_run_in && !count_hold_in &&
                      count == `WDT_CNT_MAX - 16'h0001;
    end

    // counter, state and outputs; clear lands on the fast clock so the error
    // stays within the oscillator granularity rather than waiting for a tick
    always_comb begin
        next_state        = state;
        next_count        = count;
        next_tick_seen    = tick_seen;
        next_cnt_clear    = 1'b0;
        next_internal_rst = internal_rst_out;
        next_key_rdata    = key_rdata_out;
        if (key_rd_in) begin
            next_key_rdata = tick_seen ? `WDT_READ_RUN : `WDT_READ_IDLE;
        end
        case (state)
            wdt_pkg::ST_RUN: begin
                if (bad_access) begin
                    if (osc_run_in) begin
                        next_state        = wdt_pkg::ST_RESET;
                        next_internal_rst = 1'b1;
                    end else begin
                        next_state = wdt_pkg::ST_PENDING;
                    end
                end else if (good_access) begin
                    // any time before overflow, first write included
                    next_count     = '0;
                    next_tick_seen = 1'b0;
                    next_cnt_clear = 1'b1;
                end else if (overflow) begin
                    next_state        = wdt_pkg::ST_RESET;
                    next_internal_rst = 1'b1;
                end else if (osc_tick_in && osc_run_in && !count_hold_in) begin
                    next_count     = count + 16'h0001;                  // held otherwise
                    next_tick_seen = 1'b1;
                end
            end
            wdt_pkg::ST_PENDING: begin
                if (osc_run_in) begin
                    next_state        = wdt_pkg::ST_RESET;
                    next_internal_rst = 1'b1;
                end
            end
            wdt_pkg::ST_RESET: begin
                next_internal_rst = 1'b1;   // held until system reset
            end
            default: begin
                next_state = wdt_pkg::ST_RUN;
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state            <= wdt_pkg::ST_RUN;
            count            <= '0;
            tick_seen        <= 1'b0;
            key_rdata_out    <= `WDT_READ_IDLE;
            cnt_clear_out    <= 1'b0;
            internal_rst_out <= 1'b0;
        end else begin
            state            <= next_state;
            count            <= next_count;
            tick_seen        <= next_tick_seen;
            key_rdata_out    <= next_key_rdata;
            cnt_clear_out    <= next_cnt_clear;
            internal_rst_out <= next_internal_rst;
        end
    end

    // shadow count of accepted ticks since the last service or reset; kept apart
    // from the counter so the overflow time is measured, not read back from it
    always_comb begin
        next_ticks_since_clear = ticks_since_clear;
        if (state == wdt_pkg::ST_RUN && good_access) begin
            next_ticks_since_clear = '0;
        end else if (osc_tick_in && osc_run_in && !count_hold_in &&
                     ticks_since_clear != `WDT_TICK_SAT) begin
            next_ticks_since_clear = ticks_since_clear + 17'h00001;  // saturates, never wraps
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ticks_since_clear <= '0;
        end else begin
            ticks_since_clear <= next_ticks_since_clear;
        end
    end

    // checks: reset causes and the deferred reset
    a_wrong_key_reset: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && key_wr_in && key_wdata_in != `WDT_KEY && osc_run_in)
        |=> internal_rst_out)
        else $error("wrong key gave no reset");
    a_stopped_clk_defer: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && bad_access && !osc_run_in)
        |=> !internal_rst_out)
        else $error("reset not deferred");
    a_bit_op_reset: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && key_bit_op_in && osc_run_in)
        |=> internal_rst_out)
        else $error("bit op gave no reset");
    a_bit_wins: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && key_bit_op_in && key_wr_in && key_wdata_in == `WDT_KEY)
        |=> !cnt_clear_out)
        else $error("bit op with the key counted as service");
    a_reset_cause: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && !bad_access && !overflow)
        |=> !internal_rst_out)
        else $error("reset without a cause");
    a_reset_sticky: assert property (@(posedge clk_in) disable iff (srst_in)
        internal_rst_out
        |=> internal_rst_out)
        else $error("internal reset dropped early");
    sequence s_pending;
        state == wdt_pkg::ST_PENDING && osc_run_in;
    endsequence
    a_pending_fires: assert property (@(posedge clk_in) disable iff (srst_in)
        s_pending |=> internal_rst_out ##1 internal_rst_out)
        else $error("pending reset lost");
    a_pending_waits: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_PENDING && !osc_run_in)
        |=> !internal_rst_out && state == wdt_pkg::ST_PENDING)
        else $error("pending reset fired while stopped");

    // checks: read-back, which must never echo the key
    a_read_pattern: assert property (@(posedge clk_in) disable iff (srst_in)
        key_rdata_out == `WDT_READ_RUN || key_rdata_out == `WDT_READ_IDLE)
        else $error("bad read pattern");
    a_read_holds: assert property (@(posedge clk_in) disable iff (srst_in)
        !key_rd_in |=> $stable(key_rdata_out))
        else $error("read data moved without a read");

    // checks: service, count and overflow
    a_service_clear: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && good_access && !bad_access)
        |=> count == '0 && cnt_clear_out)
        else $error("service did not clear");
    sequence s_key_service;
        state == wdt_pkg::ST_RUN && good_access;
    endsequence
    sequence s_fresh_count;
        cnt_clear_out && count == '0 && !tick_seen;
    endsequence
    a_service_restart: assert property (@(posedge clk_in) disable iff (srst_in)
        s_key_service |=> s_fresh_count)
        else $error("service did not restart the count");
    a_clear_needs_key: assert property (@(posedge clk_in) disable iff (srst_in)
        cnt_clear_out |-> $past(state == wdt_pkg::ST_RUN && good_access))
        else $error("clear without a valid key");
    a_clear_at_edge: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && good_access && !bad_access
         && count == `WDT_CNT_MAX - 16'h0001)
        |=> !internal_rst_out)
        else $error("late clear refused");
    a_hold_count: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && count_hold_in && !key_wr_in && !key_bit_op_in)
        |=> count == $past(count))
        else $error("count moved while held");
    a_stopped_no_count: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && !osc_run_in && !key_wr_in && !key_bit_op_in)
        |=> $stable(count))
        else $error("count moved while the clock was stopped");
    a_overflow_reset: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && overflow && !key_wr_in && !key_bit_op_in)
        |=> internal_rst_out)
        else $error("overflow gave no reset");
    // overflow time against the shadow count, with the allowed slack either side
    a_overflow_time: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == wdt_pkg::ST_RUN && overflow && !key_wr_in && !key_bit_op_in)
        |-> (ticks_since_clear + 17'h00001 + `WDT_OVF_SLACK >= `WDT_OVF_TICKS)
            && (ticks_since_clear + 17'h00001 <= `WDT_OVF_TICKS + `WDT_OVF_SLACK))
        else $error("overflow time out of range");
    a_no_late_overflow: assert property (@(posedge clk_in) disable iff (srst_in)
        !(state == wdt_pkg::ST_RUN && ticks_since_clear > `WDT_OVF_TICKS + `WDT_OVF_SLACK))
        else $error("counter ran past overflow");
endmodule

// ==== verilog/wdt_defines.svh ====
// constants for the key-serviced watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_KEY          8'hAC
`define WDT_READ_RUN     8'h9A
`define WDT_READ_IDLE    8'h1A
`define WDT_CNT_W        16
`define WDT_CNT_MAX      16'hFFFF
`define WDT_OSC_SYNC_W   2
`define WDT_TICK_SAT     17'h1FFFF   // shadow tick count stops here
`define WDT_OVF_TICKS    17'h0FFFF   // ticks from a clear to overflow
`define WDT_OVF_SLACK    17'h00002   // allowed overflow deviation in oscillator periods
`endif

// ==== verilog/wdt_pkg.sv ====
// types for the key-serviced watchdog
package wdt_pkg;
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_PENDING = 2'b01,
        ST_RESET   = 2'b10
    } wdt_state_e;
endpackage
